// [dao_params.svh]
`ifndef DAO_PARAMS_SVH
`define DAO_PARAMS_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define DAO_CONFIG_OFS 8'h00
`define DAO_STATUS_OFS 8'h04
`define DAO_DATA_A_OFS 8'h08
`define DAO_DATA_B_OFS 8'h0c

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define DAO_CFG_LEVEL_LSB 0
`define DAO_CFG_LEVEL_MSB 1
`define DAO_CFG_RESET 2'h0
`define DAO_ST_MODE_A_LSB 0
`define DAO_ST_MODE_B_LSB 2
`define DAO_ST_TWOS_BIT 4
`define DAO_ST_DCS_BIT 5
`define DAO_ST_SWAP_BIT 6
`define DAO_DATA_OVR_BIT 14

// ----------------------------------------
// Converter figures
// ----------------------------------------
`define DAO_CODE_WIDTH 14
`define DAO_LATENCY 5

`endif

// [dao_pkg.sv]
`include "dao_params.svh"

package dao_pkg;

    typedef enum logic [1:0] {
        DAO_NORMAL = 2'b00,
        DAO_OUT_OFF = 2'b01,
        DAO_NAP = 2'b10,
        DAO_SLEEP = 2'b11
    } dao_chan_mode_e;

    typedef enum logic [1:0] {
        DAO_LVL_GND = 2'b00,
        DAO_LVL_THIRD = 2'b01,
        DAO_LVL_TWO_THIRDS = 2'b10,
        DAO_LVL_SUPPLY = 2'b11
    } dao_level_e;

    typedef struct packed {
        logic ovr;
        logic [`DAO_CODE_WIDTH-1:0] code;
    } dao_word_s;

endpackage

// [dao_delay_line.sv]
`timescale 1ns/1ps
`default_nettype none

module dao_delay_line #(
    parameter int WIDTH = 15,
    parameter int DEPTH = 4
)(
    input wire logic clk,
    input wire logic rst,
    input wire logic adv,
    input wire logic [WIDTH-1:0] wr_data,
    output logic [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] stage_reg [DEPTH-1];
    logic [WIDTH-1:0] stage_next [DEPTH-1];
    logic [WIDTH-1:0] rd_next;

    // ----------------------------------------
    // Shift one place per advance
    // ----------------------------------------
    always_comb
    begin
        stage_next = stage_reg;
        rd_next = rd_data;
        if (adv)
        begin
            stage_next[0] = wr_data;
            for (int i = 1; i < DEPTH - 1; i++)
            begin
                stage_next[i] = stage_reg[i-1];
            end
            rd_next = stage_reg[DEPTH-2];
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            for (int i = 0; i < DEPTH - 1; i++)
            begin
                stage_reg[i] <= '0;
            end
            rd_data <= '0;
        end
        else
        begin
            stage_reg <= stage_next;
            rd_data <= rd_next;
        end
    end

endmodule

`default_nettype wire

// [dao_output_ctrl.sv]
// Functional notes
// R01: Each channel samples on its clock rise
// R02: Swap high: A to first bus
// R03: Swap low: A to second bus
// R04: Interleave needs swap and clocks tied
// R05: Words are 14 bits, bit 13 MSB
// R06: Overrange flag marks out-of-range conversions
// R07: Power-down low, enable low: drive outputs
// R08: Enable high: convert, outputs off
// R09: Power-down high, enable low: nap, off
// R10: Both high: sleep, outputs off
// R11: Channels obey their own pin pair
// R12: One level setting serves both channels
// R13: Low levels offset binary, high two's complement
// R14: Middle levels enable duty stabilizer
// R15: Output word five clock edges later
// R16: Words update once per channel clock rise
`timescale 1ns/1ps
`default_nettype none

module dao_output_ctrl
    import dao_pkg::*;
(
    input wire logic CLK,
    input wire logic RESET,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic CHAN_A_SAMPLE_CLOCK,
    input wire logic CHAN_B_SAMPLE_CLOCK,
    input wire dao_pkg::dao_word_s CHAN_A_SAMPLE_IN,
    input wire dao_pkg::dao_word_s CHAN_B_SAMPLE_IN,
    input wire logic CHAN_A_POWER_DOWN,
    input wire logic CHAN_B_POWER_DOWN,
    input wire logic CHAN_A_OUTPUT_ENABLE_N,
    input wire logic CHAN_B_OUTPUT_ENABLE_N,
    input wire logic BUS_SWAP,
    output dao_pkg::dao_word_s FIRST_BUS_WORD,
    output logic FIRST_BUS_OE,
    output dao_pkg::dao_word_s SECOND_BUS_WORD,
    output logic SECOND_BUS_OE,
    output logic DUTY_STABILIZER_ON
);
    import dao_pkg::*;

    localparam int WORD_W = $bits(dao_word_s);

    function automatic dao_chan_mode_e decode_mode(input logic pd, input logic oe_n);
        return dao_chan_mode_e'({pd, oe_n}); // [R07] [R08] [R09] [R10]
    endfunction

    function automatic dao_word_s apply_format(input dao_word_s w, input logic twos);
        dao_word_s f;
        f = w;
        f.code[`DAO_CODE_WIDTH-1] = w.code[`DAO_CODE_WIDTH-1] ^ twos; // [R13] [R05]
        return f;
    endfunction

    // ----------------------------------------
    // Sample clock edges and channel modes
    // ----------------------------------------
    logic a_clk_prev_reg, a_clk_prev_next;
    logic b_clk_prev_reg, b_clk_prev_next;
    logic a_adv, b_adv;
    dao_chan_mode_e a_mode, b_mode;

    always_comb
    begin
        a_clk_prev_next = CHAN_A_SAMPLE_CLOCK;
        b_clk_prev_next = CHAN_B_SAMPLE_CLOCK;
        a_mode = decode_mode(CHAN_A_POWER_DOWN, CHAN_A_OUTPUT_ENABLE_N); // [R11]
        b_mode = decode_mode(CHAN_B_POWER_DOWN, CHAN_B_OUTPUT_ENABLE_N); // [R11]
        // Nap and sleep stop conversion
        a_adv = CHAN_A_SAMPLE_CLOCK && !a_clk_prev_reg && !CHAN_A_POWER_DOWN; // [R01]
        b_adv = CHAN_B_SAMPLE_CLOCK && !b_clk_prev_reg && !CHAN_B_POWER_DOWN; // [R01]
    end

    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            a_clk_prev_reg <= 1'b0;
            b_clk_prev_reg <= 1'b0;
        end
        else
        begin
            a_clk_prev_reg <= a_clk_prev_next;
            b_clk_prev_reg <= b_clk_prev_next;
        end
    end

    // ----------------------------------------
    // Conversion pipelines
    // ----------------------------------------
    dao_word_s a_rd, b_rd;

    // Five delay stages plus the word register: word lands at the fifth rise after
    dao_delay_line #(.WIDTH(WORD_W), .DEPTH(`DAO_LATENCY)) u_pipe_a (
        .clk(CLK),
        .rst(RESET),
        .adv(a_adv),
        .wr_data(CHAN_A_SAMPLE_IN),
        .rd_data(a_rd)
    );

    dao_delay_line #(.WIDTH(WORD_W), .DEPTH(`DAO_LATENCY)) u_pipe_b (
        .clk(CLK),
        .rst(RESET),
        .adv(b_adv),
        .wr_data(CHAN_B_SAMPLE_IN),
        .rd_data(b_rd)
    );

    // ----------------------------------------
    // Result words and bus mapping
    // ----------------------------------------
    logic [1:0] level_reg, level_next;
    logic twos, dcs;
    dao_word_s word_a_reg, word_a_next, word_b_reg, word_b_next;
    dao_word_s first_next, second_next;
    logic first_oe_next, second_oe_next, dcs_next;
    logic a_drive, b_drive;

    always_comb
    begin
        twos = level_reg[1]; // [R12] [R13]
        dcs = level_reg[1] ^ level_reg[0]; // [R14]
        dcs_next = dcs;
        a_drive = (a_mode == DAO_NORMAL); // [R07]
        b_drive = (b_mode == DAO_NORMAL); // [R07]
        word_a_next = word_a_reg;
        word_b_next = word_b_reg;
        if (a_adv)
        begin
            word_a_next = apply_format(a_rd, twos); // [R15] [R16] [R06]
        end
        if (b_adv)
        begin
            word_b_next = apply_format(b_rd, twos); // [R15] [R16] [R06]
        end
        // Tying swap to both clocks interleaves on one bus
        if (BUS_SWAP) // [R04]
        begin
            first_next = word_a_reg; // [R02]
            second_next = word_b_reg;
            first_oe_next = a_drive;
            second_oe_next = b_drive;
        end
        else
        begin
            first_next = word_b_reg; // [R03]
            second_next = word_a_reg;
            first_oe_next = b_drive;
            second_oe_next = a_drive;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            word_a_reg <= '0;
            word_b_reg <= '0;
            FIRST_BUS_WORD <= '0;
            SECOND_BUS_WORD <= '0;
            FIRST_BUS_OE <= 1'b0;
            SECOND_BUS_OE <= 1'b0;
            DUTY_STABILIZER_ON <= 1'b0;
        end
        else
        begin
            word_a_reg <= word_a_next;
            word_b_reg <= word_b_next;
            FIRST_BUS_WORD <= first_next;
            SECOND_BUS_WORD <= second_next;
            FIRST_BUS_OE <= first_oe_next;
            SECOND_BUS_OE <= second_oe_next;
            DUTY_STABILIZER_ON <= dcs_next;
        end
    end

    // ----------------------------------------
    // AHB-Lite register slave
    // ----------------------------------------
    logic wr_pend_reg, wr_pend_next;
    logic [7:0] wr_addr_reg, wr_addr_next;
    logic [31:0] rdata_next;
    logic addr_ok;

    always_comb
    begin
        addr_ok = HSEL && HTRANS[1] && HREADY;
        wr_pend_next = addr_ok && HWRITE && (HSIZE == 3'h2);
        wr_addr_next = HADDR[7:0];
        level_next = level_reg;
        if (wr_pend_reg && wr_addr_reg == `DAO_CONFIG_OFS)
        begin
            level_next = HWDATA[`DAO_CFG_LEVEL_MSB:`DAO_CFG_LEVEL_LSB];
        end
        rdata_next = 32'h0;
        if (addr_ok && !HWRITE && HADDR[31:8] == 24'h0)
        begin
            case (HADDR[7:0])
                `DAO_CONFIG_OFS: rdata_next[`DAO_CFG_LEVEL_MSB:`DAO_CFG_LEVEL_LSB] = level_reg;
                `DAO_STATUS_OFS:
                begin
                    rdata_next[`DAO_ST_MODE_A_LSB+:2] = a_mode;
                    rdata_next[`DAO_ST_MODE_B_LSB+:2] = b_mode;
                    rdata_next[`DAO_ST_TWOS_BIT] = twos;
                    rdata_next[`DAO_ST_DCS_BIT] = dcs;
                    rdata_next[`DAO_ST_SWAP_BIT] = BUS_SWAP;
                end
                `DAO_DATA_A_OFS: rdata_next[`DAO_DATA_OVR_BIT:0] = word_a_reg;
                `DAO_DATA_B_OFS: rdata_next[`DAO_DATA_OVR_BIT:0] = word_b_reg;
                default: rdata_next = 32'h0;
            endcase
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            level_reg <= `DAO_CFG_RESET;
            HRDATA <= 32'h0;
        end
        else
        begin
            wr_pend_reg <= wr_pend_next;
            wr_addr_reg <= wr_addr_next;
            level_reg <= level_next;
            HRDATA <= rdata_next;
        end
    end

    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    swap_high_map_a: assert property (@(posedge CLK) disable iff (RESET) // [R02]
        $past(BUS_SWAP) && !$past(RESET) |-> FIRST_BUS_WORD == $past(word_a_reg)
            && SECOND_BUS_WORD == $past(word_b_reg))
        else $error("swap high did not route A to first bus");

    swap_low_map_a: assert property (@(posedge CLK) disable iff (RESET) // [R03]
        !$past(BUS_SWAP) && !$past(RESET) |-> SECOND_BUS_WORD == $past(word_a_reg)
            && FIRST_BUS_WORD == $past(word_b_reg))
        else $error("swap low did not route A to second bus");

    normal_drive_a: assert property (@(posedge CLK) disable iff (RESET) // [R07]
        $past(BUS_SWAP && !CHAN_A_POWER_DOWN && !CHAN_A_OUTPUT_ENABLE_N) && !$past(RESET)
            |-> FIRST_BUS_OE)
        else $error("normal channel A not driving");

    hiz_when_off_a: assert property (@(posedge CLK) disable iff (RESET) // [R08]
        $past(BUS_SWAP && (CHAN_A_POWER_DOWN || CHAN_A_OUTPUT_ENABLE_N)) |-> !FIRST_BUS_OE)
        else $error("channel A driving while disabled");

    nap_freeze_b: assert property (@(posedge CLK) disable iff (RESET) // [R09] [R10]
        CHAN_B_POWER_DOWN |=> $stable(word_b_reg))
        else $error("channel B converting while powered down");

    nap_freeze_a: assert property (@(posedge CLK) disable iff (RESET) // [R09] [R10]
        CHAN_A_POWER_DOWN |=> $stable(word_a_reg))
        else $error("channel A converting while powered down");

    hiz_when_off_b: assert property (@(posedge CLK) disable iff (RESET) // [R08] [R11]
        $past(BUS_SWAP && (CHAN_B_POWER_DOWN || CHAN_B_OUTPUT_ENABLE_N)) |-> !SECOND_BUS_OE)
        else $error("channel B driving while disabled");

    edge_only_a: assert property (@(posedge CLK) disable iff (RESET) // [R01] [R16]
        !(CHAN_A_SAMPLE_CLOCK && !$past(CHAN_A_SAMPLE_CLOCK)) |=> $stable(word_a_reg))
        else $error("channel A word changed without clock rise");

    format_select_a: assert property (@(posedge CLK) disable iff (RESET) // [R13]
        a_adv |=> word_a_reg.code[`DAO_CODE_WIDTH-2:0] == $past(a_rd.code[`DAO_CODE_WIDTH-2:0])
            && word_a_reg.code[`DAO_CODE_WIDTH-1]
               == ($past(a_rd.code[`DAO_CODE_WIDTH-1]) ^ $past(level_reg[1]))
            && word_a_reg.ovr == $past(a_rd.ovr))
        else $error("channel A format or flag wrong");

    format_select_b: assert property (@(posedge CLK) disable iff (RESET) // [R06] [R13]
        b_adv |=> word_b_reg.code[`DAO_CODE_WIDTH-2:0] == $past(b_rd.code[`DAO_CODE_WIDTH-2:0])
            && word_b_reg.code[`DAO_CODE_WIDTH-1]
               == ($past(b_rd.code[`DAO_CODE_WIDTH-1]) ^ $past(level_reg[1]))
            && word_b_reg.ovr == $past(b_rd.ovr))
        else $error("channel B format or flag wrong");

    stabilizer_sel_a: assert property (@(posedge CLK) disable iff (RESET) // [R14]
        !$past(RESET) |-> DUTY_STABILIZER_ON
            == ($past(level_reg) == 2'h1 || $past(level_reg) == 2'h2))
        else $error("stabilizer setting wrong");

    indep_chan_b: assert property (@(posedge CLK) disable iff (RESET) // [R11]
        !$past(BUS_SWAP) && !$past(RESET) && $past(CHAN_A_POWER_DOWN)
            && !$past(CHAN_B_POWER_DOWN) && !$past(CHAN_B_OUTPUT_ENABLE_N) |-> FIRST_BUS_OE)
        else $error("channel B affected by channel A pins");

endmodule

`default_nettype wire

// [dao_rx_model.sv]
`timescale 1ns/1ps
`default_nettype none

module dao_rx_model
    import dao_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ilv,
    input wire logic fix_swap,
    input wire dao_pkg::dao_word_s bus_in,
    input wire logic bus_oe,
    output logic samp_clk,
    output logic swap,
    output logic [7:0] idx,
    output dao_pkg::dao_word_s got
);
    logic [1:0] cnt;

    // ----------------------------------------
    // Sample clock, two cycles high, two low
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cnt <= 2'h0;
            idx <= 8'h00;
            got <= '0;
        end
        else
        begin
            cnt <= cnt + 2'h1;
            if (cnt == 2'h3)
                idx <= idx + 8'h01;
            // Released bus shows inverted last value
            got <= bus_oe ? bus_in : ~got;
        end
    end

    assign samp_clk = cnt[1];
    assign swap = ilv ? samp_clk : fix_swap;
endmodule

`default_nettype wire

// [testbench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dao_params.svh"

module testbench;
    import dao_pkg::*;
    logic CLK, RESET, HSEL, HWRITE, hrdy, hresp, pd_a, oe_a, ilv, fsw, sclk, sw, oe1, oe2, dcs;
    logic pd_b, oe_b;
    logic [31:0] HADDR, HWDATA, HRDATA, rd, frz;
    logic [1:0] HTRANS;
    logic [2:0] HSIZE;
    logic [7:0] idx;
    dao_word_s a_in, b_in, w1, w2, got;
    int n_fail, comparisons, r;

    dao_output_ctrl uut (.CLK(CLK), .RESET(RESET), .HSEL(HSEL), .HADDR(HADDR),
        .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(hrdy),
        .HRDATA(HRDATA), .HREADYOUT(hrdy), .HRESP(hresp), .CHAN_A_SAMPLE_CLOCK(sclk),
        .CHAN_B_SAMPLE_CLOCK(sclk), .CHAN_A_SAMPLE_IN(a_in), .CHAN_B_SAMPLE_IN(b_in),
        .CHAN_A_POWER_DOWN(pd_a), .CHAN_B_POWER_DOWN(pd_b), .CHAN_A_OUTPUT_ENABLE_N(oe_a),
        .CHAN_B_OUTPUT_ENABLE_N(oe_b), .BUS_SWAP(sw), .FIRST_BUS_WORD(w1),
        .FIRST_BUS_OE(oe1), .SECOND_BUS_WORD(w2), .SECOND_BUS_OE(oe2),
        .DUTY_STABILIZER_ON(dcs));
    dao_rx_model rx (.clk(CLK), .rst(RESET), .ilv(ilv), .fix_swap(fsw), .bus_in(w1),
        .bus_oe(oe1), .samp_clk(sclk), .swap(sw), .idx(idx), .got(got));

    // ----------------------------------------
    // Sample source and expected words
    // ----------------------------------------
    function automatic dao_word_s ex(input int n, input logic b, input logic tw);
        logic [13:0] c;
        c = b ? 14'(16'h3000 - n) : 14'(n * 37);
        return {b ? n[0] : (n[1:0] == 2'h3), c ^ {tw, 13'h0}};
    endfunction
    assign a_in = ex(int'(idx), 1'b0, 1'b0);
    assign b_in = ex(int'(idx), 1'b1, 1'b0);

    initial
    begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end

    task check(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e)
        begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK);
        HTRANS <= 2'h2;
        HADDR <= {24'h0, a};
        HWRITE <= w;
        HSIZE <= 3'h2;
        do @(posedge CLK); while (hrdy !== 1'b1);
        HTRANS <= 2'h0;
        HWDATA <= d;
        do @(posedge CLK); while (hrdy !== 1'b1);
        rd = HRDATA;
    endtask

    task sync(input logic [1:0] ph);
        do
        begin
            @(posedge CLK);
            #1;
        end
        while (rx.cnt !== ph);
    endtask

    task stream(input logic s, input logic tw);
        repeat (8) sync(2'h1);
        repeat (4)
        begin
            sync(2'h1);
            r = int'(idx) - 6;
            check(got, s ? ex(r, 0, tw) : ex(r, 1, tw));
            check(w2, s ? ex(r, 1, tw) : ex(r, 0, tw));
            check(oe1 & oe2, 1'b1);
        end
    endtask

    task summarize;
        $display("checks %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        #100000;
        n_fail++;
        summarize;
    end

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial
    begin
        {HSEL, HADDR, HTRANS, HWRITE, HSIZE, HWDATA} = '0;
        {pd_a, oe_a, pd_b, oe_b, ilv, fsw, RESET, n_fail, comparisons} = '0;
        HSEL = 1'b1;
        fsw = 1'b1;
        RESET = 1'b1;
        repeat (2) @(posedge CLK);
        RESET <= 1'b0;
        #1;
        check({w1, w2}, 32'h0);
        check({oe1, oe2, dcs}, 32'h0);
        ahb(1'b0, `DAO_CONFIG_OFS, 32'h0);
        check(rd, 32'h0);
        check(hresp, 1'b0);
        $display("test reset done");
        for (int lv = 0; lv < 4; lv++)
        begin
            ahb(1'b1, `DAO_CONFIG_OFS, 32'(lv));
            ahb(1'b0, `DAO_CONFIG_OFS, 32'h0);
            check(rd, 32'(lv));
            check(dcs, lv == 1 || lv == 2);
            stream(1'b1, lv[1]);
        end
        $display("test format done");
        fsw <= 1'b0;
        stream(1'b0, 1'b1);
        $display("test swap done");
        ilv <= 1'b1;
        repeat (8) sync(2'h1);
        sync(2'h0);
        r = int'(idx) - 6;
        check(w1, ex(r, 0, 1));
        sync(2'h2);
        check(w1, ex(r, 1, 1));
        ilv <= 1'b0;
        fsw <= 1'b1;
        $display("test interleave done");
        for (int k = 0; k < 8; k++)
        begin
            @(posedge CLK);
            fsw <= k[2];
            pd_a <= k[1];
            oe_a <= k[0];
            repeat (3) @(posedge CLK);
            #1;
            check(k[2] ? oe1 : oe2, k[1:0] == 2'h0);
            check(k[2] ? oe2 : oe1, 1'b1);
            ahb(1'b0, `DAO_STATUS_OFS, 32'h0);
            check(rd[3:0], {2'h0, k[1:0]});
        end
        @(posedge CLK);
        pd_a <= 1'b0;
        oe_a <= 1'b0;
        pd_b <= 1'b1;
        ahb(1'b0, `DAO_DATA_B_OFS, 32'h0);
        frz = rd;
        repeat (2) sync(2'h1);
        ahb(1'b0, `DAO_DATA_B_OFS, 32'h0);
        check(rd, frz);
        check(oe2, 1'b0);
        check(oe1, 1'b1);
        @(posedge CLK);
        oe_b <= 1'b1;
        repeat (3) @(posedge CLK);
        #1;
        check(oe2, 1'b0);
        ahb(1'b0, `DAO_STATUS_OFS, 32'h0);
        check(rd[3:0], 4'hc);
        @(posedge CLK);
        pd_b <= 1'b0;
        oe_b <= 1'b0;
        $display("test modes done");
        ahb(1'b1, 8'h40, 32'hffffffff);
        ahb(1'b0, 8'h40, 32'h0);
        check(rd, 32'h0);
        ahb(1'b1, `DAO_STATUS_OFS, 32'h0);
        ahb(1'b0, `DAO_STATUS_OFS, 32'h0);
        check(rd[6:0], 7'h50);
        $display("test access done");
        summarize;
    end
endmodule

`default_nettype wire
